// file: rtl/ufap_core.sv
// usb address, power, suspend and iso gate control
//
// Behaviour
// - address write sets update flag; cleared on apply
// - seven bit address, read/write, resets zero
// - old address kept until request completes
// - bus reset detection shows in reset bit
// - bus reset zeroes address, flushes fifos
// - bus reset clears endpoint csrs
// - bus reset enables wake and reset irqs, clears flags, raises reset
// - writing reset bit resets all usb registers except osc_wake
// - suspend entered when enabled; optional suspend irq
// - suspend left on resume, bus or device reset
// - oscillator woken on any suspend exit event
// - bus resume exits suspend, optional resume irq
// - force resume bit drives resume signaling
// - iso gate holds loaded iso packets until sof
// - iso token before sof answered zero length
// - function inhibited after power on, traffic ignored
// - inhibit only reset back by resets
// - suspend status set on entry, cleared as documented
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ufap_core #(
    parameter int AW  = 4,
    parameter int NEP = 3
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AW-1:0]         s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output ufap_pkg::ufap_resp_t       s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AW-1:0]         s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output ufap_pkg::ufap_resp_t       s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  bus_reset_level,
    input  wire logic                  suspend_seen,
    input  wire logic                  resume_seen,
    input  wire logic                  sof_seen,
    input  wire logic                  request_done,
    input  wire logic [NEP-1:0]        iso_in_loaded,
    input  wire logic [NEP-1:0]        iso_in_token,
    output logic [6:0]                 active_address,
    output logic                       function_inhibit,
    output logic                       suspended,
    output logic                       resume_drive,
    output logic                       osc_wake,
    output logic                       fifo_flush,
    output logic                       ep_csr_clear,
    output logic [NEP-1:0]             iso_send_data,
    output logic [NEP-1:0]             iso_send_zlp
);
    import ufap_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // address decode
    function automatic logic [2:0] reg_decode(input logic [AW-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a[1:0] != 2'b00) begin
            r = 3'h0;
        end else if (int'(a[AW-1:2]) < REG_COUNT) begin
            r = {1'b1, a[3:2]};
        end
        return r;
    endfunction : reg_decode

    logic              awready_r;
    logic              wready_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [AW-1:0]     awaddr_r;
    logic [7:0]        wdata_r;
    logic              wstrb0_r;
    logic              bvalid_r;
    ufap_resp_t        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    ufap_resp_t        rresp_r;
    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              do_wr;
    logic [2:0]        wr_dec;
    logic [2:0]        rd_dec;
    logic              wr_en;

    assign aw_take = s_axi_awvalid & awready_r;
    assign w_take  = s_axi_wvalid & wready_r;
    assign ar_take = s_axi_arvalid & arready_r;
    assign do_wr   = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_dec  = reg_decode(awaddr_r);
    assign rd_dec  = reg_decode(s_axi_araddr);
    // lane zero holds every register
    assign wr_en   = do_wr & wr_dec[2] & wstrb0_r;

    ////////////////////////////////////////////////////////////////////
    // axi write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awready_r <= 1'b0;
            awaddr_r  <= '0;
        end else begin
            if (do_wr) begin
                aw_held_r <= 1'b0;
            end else if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            awready_r <= do_wr | (~aw_held_r & ~aw_take);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wready_r <= 1'b0;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
        end else begin
            if (do_wr) begin
                w_held_r <= 1'b0;
            end else if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            wready_r <= do_wr | (~w_held_r & ~w_take);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= UFAP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_dec[2] ? UFAP_OKAY : UFAP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // usb side state
    logic [1:0]        swrst_cnt_r;
    logic              usb_rst_r;
    logic              usb_clr;
    logic              sw_rst_req;
    logic [6:0]        pend_addr_r;
    logic              upd_r;
    logic [6:0]        act_addr_r;
    logic              iso_gate_r;
    logic              inh_r;
    logic              bus_rst_lvl_r;
    logic              force_res_r;
    logic              susp_stat_r;
    logic              sen_r;
    logic [2:0]        irq_en_r;
    logic [2:0]        irq_flags_r;
    logic              resume_pend_r;
    ufap_pm_t          pm_r;
    logic              bus_rst_evt;
    logic              susp_evt;
    logic              resume_evt;
    logic              force_wr1;
    logic              wake_evt;
    logic              pw_wr;
    logic              flags_rd;
    logic [2:0]        irq_set;
    logic [7:0]        power_rd;

    assign pw_wr      = wr_en & (wr_dec[1:0] == 2'(IDX_POWER));
    assign sw_rst_req = pw_wr & wdata_r[PW_RST_BIT];
    assign usb_clr    = ~aresetn | usb_rst_r;
    assign flags_rd   = ar_take & rd_dec[2]
                      & (rd_dec[1:0] == 2'(IDX_IRQ_FLAGS));
    // inhibit mutes bus events
    assign bus_rst_evt = bus_reset_level & ~bus_rst_lvl_r & ~inh_r;
    assign susp_evt    = sen_r & suspend_seen & ~inh_r
                       & (pm_r == UFAP_PM_ACTIVE);
    assign resume_evt  = resume_seen & ~inh_r
                       & (pm_r == UFAP_PM_SUSPENDED);
    assign force_wr1   = pw_wr & wdata_r[PW_RES_BIT];
    assign wake_evt    = resume_evt | force_wr1 | bus_rst_evt;
    assign irq_set     = {bus_rst_evt & irq_en_r[IRQ_RST_BIT],
                          resume_evt & irq_en_r[IRQ_WAKE_BIT],
                          susp_evt & irq_en_r[IRQ_SUS_BIT]};

    ////////////////////////////////////////////////////////////////////
    // forced usb reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swrst_cnt_r <= 2'h0;
            usb_rst_r   <= 1'b1;
        end else begin
            if (sw_rst_req) begin
                swrst_cnt_r <= SWRST_CYC;
            end else if (swrst_cnt_r != 2'h0) begin
                swrst_cnt_r <= swrst_cnt_r - 2'h1;
            end
            usb_rst_r <= (swrst_cnt_r != 2'h0) | sw_rst_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // function address
    always_ff @(posedge aclk) begin
        if (usb_clr || bus_rst_evt) begin
            pend_addr_r <= FA_RESET;
            act_addr_r  <= FA_RESET;
            upd_r       <= 1'b0;
        end else if (wr_en && wr_dec[1:0] == 2'(IDX_FUNC_ADDR)) begin
            pend_addr_r <= wdata_r[6:0];
            upd_r       <= 1'b1;
        end else if (upd_r && request_done && !inh_r) begin
            // old address stays until request ends
            act_addr_r <= pend_addr_r;
            upd_r      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power control bits
    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            iso_gate_r  <= 1'b0;
            inh_r       <= PW_INH_RESET;
            force_res_r <= 1'b0;
            sen_r       <= 1'b0;
        end else if (pw_wr) begin
            iso_gate_r  <= wdata_r[PW_ISO_BIT];
            // software only clears it
            inh_r       <= inh_r & wdata_r[PW_INH_BIT];
            force_res_r <= wdata_r[PW_RES_BIT];
            sen_r       <= wdata_r[PW_SEN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            bus_rst_lvl_r <= 1'b0;
        end else begin
            bus_rst_lvl_r <= bus_reset_level & ~inh_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // suspend state
    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            pm_r <= UFAP_PM_ACTIVE;
        end else begin
            case (pm_r)
                UFAP_PM_ACTIVE: begin
                    if (susp_evt) begin
                        pm_r <= UFAP_PM_SUSPENDED;
                    end
                end
                UFAP_PM_SUSPENDED: begin
                    if (wake_evt) begin
                        pm_r <= UFAP_PM_ACTIVE;
                    end
                end
                default: begin
                    pm_r <= UFAP_PM_ACTIVE;
                end
            endcase
        end
    end

    // status lags mode until software notices
    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            susp_stat_r   <= 1'b0;
            resume_pend_r <= 1'b0;
        end else begin
            if (susp_evt) begin
                susp_stat_r <= 1'b1;
            end else if ((pw_wr && force_res_r && !wdata_r[PW_RES_BIT])
                         || (flags_rd && resume_pend_r)) begin
                susp_stat_r <= 1'b0;
            end
            if (resume_evt) begin
                resume_pend_r <= 1'b1;
            end else if (flags_rd) begin
                resume_pend_r <= 1'b0;
            end
        end
    end

    // no usb reset: survives a forced reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_wake <= 1'b0;
        end else begin
            osc_wake <= (pm_r == UFAP_PM_SUSPENDED)
                      & (wake_evt | sw_rst_req);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // irq enables and sticky flags, read clears, set wins
    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            irq_en_r <= IRQ_EN_RESET;
        end else if (bus_rst_evt) begin
            irq_en_r <= irq_en_r | IRQ_BUSRST_EN;
        end else if (wr_en && wr_dec[1:0] == 2'(IDX_IRQ_EN)) begin
            irq_en_r <= wdata_r[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            irq_flags_r <= IRQ_FLAGS_RESET;
        end else if (bus_rst_evt) begin
            irq_flags_r <= {1'b1, 2'b00};
        end else if (flags_rd) begin
            irq_flags_r <= irq_set;
        end else begin
            irq_flags_r <= irq_flags_r | irq_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // endpoint side effects of a bus reset
    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            fifo_flush   <= 1'b0;
            ep_csr_clear <= 1'b0;
        end else begin
            fifo_flush   <= bus_rst_evt;
            ep_csr_clear <= bus_rst_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // iso in gating per endpoint
    logic [NEP-1:0] iso_hold_r;
    logic [NEP-1:0] iso_ready_r;
    logic           sof_evt;

    assign sof_evt = sof_seen & ~inh_r;

    for (genvar i = 0; i < NEP; i++) begin : g_iso
        logic tok;
        logic go;
        assign tok = iso_in_token[i] & ~inh_r;
        assign go  = tok & iso_ready_r[i] & ~iso_hold_r[i];
        always_ff @(posedge aclk) begin
            if (usb_clr || bus_rst_evt) begin
                iso_hold_r[i]    <= 1'b0;
                iso_ready_r[i]   <= 1'b0;
                iso_send_data[i] <= 1'b0;
                iso_send_zlp[i]  <= 1'b0;
            end else begin
                if (iso_in_loaded[i]) begin
                    iso_ready_r[i] <= 1'b1;
                end else if (go) begin
                    iso_ready_r[i] <= 1'b0;
                end
                if (iso_in_loaded[i] && iso_gate_r) begin
                    iso_hold_r[i] <= 1'b1;
                end else if (sof_evt) begin
                    iso_hold_r[i] <= 1'b0;
                end
                iso_send_data[i] <= go;
                iso_send_zlp[i]  <= tok & ~go;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi read channel
    assign power_rd = {iso_gate_r, 2'b00, inh_r, bus_rst_lvl_r,
                       force_res_r, susp_stat_r, sen_r};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= UFAP_OKAY;
        end else begin
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= rd_dec[2] ? UFAP_OKAY : UFAP_SLVERR;
                rdata_r   <= 32'h0000_0000;
                if (!rd_dec[2]) begin
                    rdata_r <= 32'h0000_0000;
                end else if (rd_dec[1:0] == 2'(IDX_FUNC_ADDR)) begin
                    rdata_r[7:0] <= {upd_r, pend_addr_r};
                end else if (rd_dec[1:0] == 2'(IDX_POWER)) begin
                    rdata_r[7:0] <= power_rd;
                end else if (rd_dec[1:0] == 2'(IDX_IRQ_EN)) begin
                    rdata_r[2:0] <= irq_en_r;
                end else begin
                    rdata_r[2:0] <= irq_flags_r;
                end
            end else begin
                if (rvalid_r && s_axi_rready) begin
                    rvalid_r <= 1'b0;
                end
                arready_r <= ~rvalid_r | s_axi_rready;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready    = awready_r;
    assign s_axi_wready     = wready_r;
    assign s_axi_bvalid     = bvalid_r;
    assign s_axi_bresp      = bresp_r;
    assign s_axi_arready    = arready_r;
    assign s_axi_rvalid     = rvalid_r;
    assign s_axi_rdata      = rdata_r;
    assign s_axi_rresp      = rresp_r;
    assign active_address   = act_addr_r;
    assign function_inhibit = inh_r;
    assign resume_drive     = force_res_r;
    always_ff @(posedge aclk) begin
        if (usb_clr) begin
            suspended <= 1'b0;
        end else begin
            suspended <= (pm_r == UFAP_PM_SUSPENDED) & ~wake_evt;
        end
    end
endmodule : ufap_core

// file: rtl/ufap_pkg.sv
// shared constants and types of ufap_core
package ufap_pkg;
    // register index; byte address is 4x index
    localparam int IDX_FUNC_ADDR = 0;
    localparam int IDX_POWER     = 1;
    localparam int IDX_IRQ_EN    = 2;
    localparam int IDX_IRQ_FLAGS = 3;
    localparam int REG_COUNT     = 4;
    // function_address fields
    localparam int FA_UPDATE_BIT = 7;
    localparam logic [6:0] FA_RESET = 7'h00;
    // device_power_control fields
    localparam int PW_ISO_BIT = 7;
    localparam int PW_INH_BIT = 4;
    localparam int PW_RST_BIT = 3;
    localparam int PW_RES_BIT = 2;
    localparam int PW_SUS_BIT = 1;
    localparam int PW_SEN_BIT = 0;
    localparam logic PW_INH_RESET = 1'b1;
    // irq enable and flag fields
    localparam int IRQ_SUS_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam int IRQ_RST_BIT = 2;
    localparam logic [2:0] IRQ_EN_RESET = 3'h6;
    localparam logic [2:0] IRQ_BUSRST_EN = 3'h6;
    localparam logic [2:0] IRQ_FLAGS_RESET = 3'h0;
    // extra cycles of forced usb reset
    localparam logic [1:0] SWRST_CYC = 2'h2;
    typedef enum logic [1:0] {
        UFAP_OKAY   = 2'b00,
        UFAP_SLVERR = 2'b10
    } ufap_resp_t;
    typedef enum logic {
        UFAP_PM_ACTIVE    = 1'b0,
        UFAP_PM_SUSPENDED = 1'b1
    } ufap_pm_t;
endpackage : ufap_pkg

// file: verif/tb_top.sv
// self-checking bench for ufap_core
`timescale 1ns/1ps
module tb_top;
    import ufap_pkg::*;
    typedef struct {
        logic [3:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
        ufap_resp_t resp;
    } ufap_row_t;
    logic        aclk, aresetn, go;
    logic [2:0]  cmd;
    logic [1:0]  ep;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    ufap_resp_t  s_axi_bresp, s_axi_rresp, rsp;
    logic        bus_reset_level, suspend_seen, resume_seen, sof_seen;
    logic        request_done, function_inhibit, suspended, resume_drive;
    logic        osc_wake, fifo_flush, ep_csr_clear;
    logic [2:0]  iso_in_loaded, iso_in_token, iso_send_data, iso_send_zlp;
    logic [2:0]  got_data, got_zlp;
    logic        got_osc, got_flush, got_clr;
    logic [6:0]  active_address;
    int          fails, n_compared;
    ufap_row_t   rows [5] = '{
        '{4'h0, 8'h55, 8'hD5, UFAP_OKAY}, '{4'h4, 8'hE5, 8'h85, UFAP_OKAY},
        '{4'h4, 8'h91, 8'h81, UFAP_OKAY}, '{4'h8, 8'h07, 8'h07, UFAP_OKAY},
        '{4'h2, 8'h00, 8'h00, UFAP_SLVERR}};
    logic [7:0]  dflt [4] = '{8'h00, 8'h10, 8'h06, 8'h00};

    ufap_core u_ufap_core (.*);
    ufap_host_model u_ufap_host_model (.*);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    // latch pulses since the last host command
    always @(posedge aclk) begin
        got_data  <= go ? 3'h0 : got_data | iso_send_data;
        got_zlp   <= go ? 3'h0 : got_zlp | iso_send_zlp;
        got_osc   <= !go && (got_osc || osc_wake);
        got_flush <= !go && (got_flush || fifo_flush);
        got_clr   <= !go && (got_clr || ep_csr_clear);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
                          output ufap_resp_t r);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        if (n == 40) begin
            fails++;
            tally_and_finish();
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output ufap_resp_t r);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        if (n == 40) begin
            fails++;
            tally_and_finish();
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_rd
    task automatic host(input logic [2:0] c, input logic [1:0] e);
        @(posedge aclk);
        cmd <= c;
        ep  <= e;
        go  <= 1'h1;
        @(posedge aclk);
        go  <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask : host
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, go, cmd, ep, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        fails = 0;
        n_compared = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            axi_wr(rows[i].addr, rows[i].wd, rsp);
            chk("bresp", rsp, rows[i].resp);
            axi_rd(rows[i].addr, rdv, rsp);
            chk("rdata", rdv, {24'h00_0000, rows[i].rd});
            chk("rresp", rsp, rows[i].resp);
        end
        chk("active_address", active_address, 7'h00);
        host(3'h5, 2'h0);
        chk("active_address", active_address, 7'h55);
        axi_rd(4'h0, rdv, rsp);
        chk("function_address", rdv, 32'h0000_0055);
        host(3'h6, 2'h1);
        host(3'h7, 2'h1);
        chk("iso_zlp", {got_data, got_zlp}, 6'h02);
        host(3'h4, 2'h0);
        host(3'h7, 2'h1);
        chk("iso_data", {got_data, got_zlp}, 6'h10);
        axi_wr(4'h4, 8'h01, rsp);
        host(3'h6, 2'h0);
        host(3'h7, 2'h0);
        chk("iso_data", {got_data, got_zlp}, 6'h08);
        host(3'h2, 2'h0);
        chk("suspended", suspended, 1'h1);
        axi_rd(4'h4, rdv, rsp);
        chk("power", rdv, 32'h0000_0003);
        axi_rd(4'hC, rdv, rsp);
        chk("irq_flags", rdv, 32'h0000_0001);
        host(3'h3, 2'h0);
        chk("suspended", suspended, 1'h0);
        chk("osc_wake", got_osc, 1'h1);
        axi_rd(4'hC, rdv, rsp);
        chk("irq_flags", rdv, 32'h0000_0002);
        host(3'h1, 2'h0);
        axi_rd(4'h4, rdv, rsp);
        chk("power", rdv, 32'h0000_0009);
        chk("flush", {got_flush, got_clr}, 2'h3);
        chk("active_address", active_address, 7'h00);
        axi_rd(4'hC, rdv, rsp);
        chk("irq_flags", rdv, 32'h0000_0004);
        axi_rd(4'h8, rdv, rsp);
        chk("irq_enable", rdv, 32'h0000_0007);
        axi_wr(4'h4, 8'h08, rsp);
        repeat (6) @(posedge aclk);
        chk("function_inhibit", function_inhibit, 1'h1);
        for (int i = 0; i < 4; i++) begin
            axi_rd(4'(i * 4), rdv, rsp);
            chk("default", rdv, {24'h00_0000, dflt[i]});
        end
        host(3'h7, 2'h0);
        chk("inhibited_token", {got_data, got_zlp}, 6'h00);
        tally_and_finish();
    end
endmodule : tb_top

// file: verif/ufap_core_properties.sv
// port assertions for ufap_core
`timescale 1ns/1ps
module ufap_core_properties #(
    parameter int NEP = 3
) (
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           s_axi_bvalid,
    input wire logic           bus_reset_level,
    input wire logic           suspend_seen,
    input wire logic           resume_seen,
    input wire logic           request_done,
    input wire logic [NEP-1:0] iso_in_token,
    input wire logic [6:0]     active_address,
    input wire logic           function_inhibit,
    input wire logic           suspended,
    input wire logic           resume_drive,
    input wire logic           osc_wake,
    input wire logic           fifo_flush,
    input wire logic           ep_csr_clear,
    input wire logic [NEP-1:0] iso_send_data,
    input wire logic [NEP-1:0] iso_send_zlp
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    bus_reset_a: assert property (
        $rose(bus_reset_level) && !function_inhibit |-> ##[1:2]
        (fifo_flush && ep_csr_clear && active_address == 7'h00))
        else $error("reset effects missing");
    flush_pulse_a: assert property (
        fifo_flush |-> $past(bus_reset_level) && ep_csr_clear ##1 !fifo_flush)
        else $error("bad flush pulse");
    addr_commit_a: assert property (
        $changed(active_address) && active_address != 7'h00
        |-> $past(request_done))
        else $error("early address change");
    suspend_entry_a: assert property (
        $rose(suspended) |-> $past(suspend_seen) || $past(suspend_seen, 2))
        else $error("unprompted suspend");
    resume_exit_a: assert property (
        suspended && resume_seen && !function_inhibit |-> ##[1:2] !suspended)
        else $error("resume ignored");
    osc_wake_a: assert property (
        suspended && resume_seen && !function_inhibit |-> ##[1:2] osc_wake)
        else $error("no oscillator wake");
    iso_answer_a: assert property (
        !function_inhibit && iso_in_token != '0 |=>
        (iso_send_data | iso_send_zlp) == $past(iso_in_token)
        && (iso_send_data & iso_send_zlp) == '0)
        else $error("iso answer wrong");
    inhibit_mute_a: assert property (
        function_inhibit && iso_in_token != '0 |=>
        iso_send_data == '0 && iso_send_zlp == '0)
        else $error("inhibited answer");
    resume_drive_a: assert property (
        $rose(resume_drive) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("stray resume drive");
    sus_c: cover property ($rose(suspended));
    flush_c: cover property (fifo_flush);
    zlp_c: cover property (iso_send_zlp != '0);
endmodule : ufap_core_properties
////////////////////////////////////////////////////////////////////////////
bind ufap_core ufap_core_properties #(.NEP(NEP)) u_ufap_core_properties (.*);

// file: verif/ufap_host_model.sv
// host side model raising link events
`timescale 1ns/1ps
module ufap_host_model #(
    parameter int NEP     = 3,
    parameter int RST_LEN = 16
) (
    input  wire logic           aclk,
    input  wire logic           aresetn,
    input  wire logic           go,
    input  wire logic [2:0]     cmd,
    input  wire logic [1:0]     ep,
    output logic                bus_reset_level,
    output logic                suspend_seen,
    output logic                resume_seen,
    output logic                sof_seen,
    output logic                request_done,
    output logic [NEP-1:0]      iso_in_loaded,
    output logic [NEP-1:0]      iso_in_token
);
    logic [7:0]     rst_cnt_r;
    logic [NEP-1:0] ep_hot;
    assign ep_hot = {{(NEP-1){1'h0}}, 1'h1} << ep;
    assign bus_reset_level = (rst_cnt_r != 8'h00);
    // level outlasts a register read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt_r <= 8'h00;
        end else if (go && cmd == 3'h1) begin
            rst_cnt_r <= 8'(RST_LEN);
        end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
        end
    end
    // other events pulse once
    always_ff @(posedge aclk) begin
        suspend_seen  <= aresetn && go && cmd == 3'h2;
        resume_seen   <= aresetn && go && cmd == 3'h3;
        sof_seen      <= aresetn && go && cmd == 3'h4;
        request_done  <= aresetn && go && cmd == 3'h5;
        iso_in_loaded <= (aresetn && go && cmd == 3'h6) ? ep_hot : '0;
        iso_in_token  <= (aresetn && go && cmd == 3'h7) ? ep_hot : '0;
    end
endmodule : ufap_host_model
